// ### sebc_map.vh
`ifndef SEBC_MAP_VH
`define SEBC_MAP_VH
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SEBC_CLK_HZ          25000000
`define SEBC_T_ON_MS         300
`define SEBC_T_OFF_MS        300
`define SEBC_T_PERIOD_MS     2000
// Cycle counts at 25 MHz, sized to the 27-bit sequencer counters
`define SEBC_ON_CYC          27'd7500000
`define SEBC_OFF_CYC         27'd7500000
`define SEBC_PERIOD_CYC      27'd50000000
// ----------------------------------------------------------------------------
// Fault source bit positions (fault vector index)
// ----------------------------------------------------------------------------
`define SEBC_SRC_WIDTH       19
`define SEBC_SRC_UNDEF_INSTR 0
`define SEBC_SRC_SW_INT      1
`define SEBC_SRC_PREFETCH    2
`define SEBC_SRC_DATA_ABORT  3
`define SEBC_SRC_ADDR_ERR    4
`define SEBC_SRC_WORK_MEM    5
`define SEBC_SRC_PLD_LOAD    6
`define SEBC_SRC_IRQ_SRC1    7
`define SEBC_SRC_IRQ_SRC2    8
`define SEBC_SRC_NO_MAC      9
`define SEBC_SRC_STDIO       10
`define SEBC_SRC_THREAD1     11
`define SEBC_SRC_THREAD2     12
`define SEBC_SRC_POST_DMA    13
`define SEBC_SRC_POST_MEMDMA 14
`define SEBC_SRC_POST_ETH    15
`define SEBC_SRC_POST_IRQ    16
`define SEBC_SRC_POST_MII    17
`define SEBC_SRC_POST_CACHE  18
// ----------------------------------------------------------------------------
// Blink codes
// ----------------------------------------------------------------------------
`define SEBC_CODE_NONE       5'h00
`define SEBC_CODE_UNDEF      5'h01
`define SEBC_CODE_SWI        5'h02
`define SEBC_CODE_PREFETCH   5'h03
`define SEBC_CODE_DABORT     5'h04
`define SEBC_CODE_ADDR       5'h05
`define SEBC_CODE_MEM        5'h06
`define SEBC_CODE_PLD        5'h07
`define SEBC_CODE_IRQ1       5'h08
`define SEBC_CODE_IRQ2       5'h09
`define SEBC_CODE_NO_MAC     5'h0A
`define SEBC_CODE_STDIO      5'h0B
`define SEBC_CODE_THREAD1    5'h0C
`define SEBC_CODE_THREAD2    5'h0D
`define SEBC_CODE_POST_DMA   5'h0F
`define SEBC_CODE_POST_MDMA  5'h10
`define SEBC_CODE_POST_ETH   5'h11
`define SEBC_CODE_POST_IRQ   5'h12
`define SEBC_CODE_POST_MII   5'h13
`define SEBC_CODE_POST_CACHE 5'h14
`endif

// ### sebc_blink.v
// Operation
// - Any listed internal fault is a system error; both lamps blink together.
// - Each blink 300 ms on, 300 ms off; the group restarts every 2 s, so only codes 1 to 3 show all n blinks.
// - Processor faults give codes 1 to 5 in the listed order.
// - Working-memory fault gives code 6.
// - Logic-device configuration load failure gives code 7.
// - Unknown interrupt one 8, two 9, standard I/O init failure 11.
// - Missing MAC address gives code 10.
// - System thread one init failure 12, thread two 13.
// - Self-test: internal DMA 15, memory-to-DMA 16.
// - Self-test: Ethernet loopback 17, interrupt generation 18.
// - Self-test: MII interface 19, cache 20.
`timescale 1ns/1ps
`include "sebc_map.vh"

module sebc_blink (
   input  wire        clk_sys,          // System clock, 25 MHz
   input  wire        reset_n,          // Asynchronous reset, active low
   input  wire [18:0] fault_in,         // Fault sources, level, asynchronous
   output reg         green_indicator,  // Green lamp, high = lit
   output reg         red_indicator,    // Red lamp, high = lit
   output reg  [4:0]  error_code,       // Latched blink code, 0 = none
   output reg         error_active      // High once a code is latched
);

   localparam [26:0] ON_CYC     = `SEBC_ON_CYC;
   localparam [26:0] OFF_CYC    = `SEBC_OFF_CYC;
   localparam [26:0] PERIOD_CYC = `SEBC_PERIOD_CYC;

   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_ON    = 3'h2;
   localparam [2:0] ST_OFF   = 3'h4;

   // -------------------------------------------------------------------------
   // Code lookup, lowest fault index wins
   // -------------------------------------------------------------------------
   function [4:0] code_of;
      input [18:0] f;
      begin
         if (f[`SEBC_SRC_UNDEF_INSTR])
            code_of = `SEBC_CODE_UNDEF;
         else if (f[`SEBC_SRC_SW_INT])
            code_of = `SEBC_CODE_SWI;
         else if (f[`SEBC_SRC_PREFETCH])
            code_of = `SEBC_CODE_PREFETCH;
         else if (f[`SEBC_SRC_DATA_ABORT])
            code_of = `SEBC_CODE_DABORT;
         else if (f[`SEBC_SRC_ADDR_ERR])
            code_of = `SEBC_CODE_ADDR;
         else if (f[`SEBC_SRC_WORK_MEM])
            code_of = `SEBC_CODE_MEM;
         else if (f[`SEBC_SRC_PLD_LOAD])
            code_of = `SEBC_CODE_PLD;
         else if (f[`SEBC_SRC_IRQ_SRC1])
            code_of = `SEBC_CODE_IRQ1;
         else if (f[`SEBC_SRC_IRQ_SRC2])
            code_of = `SEBC_CODE_IRQ2;
         else if (f[`SEBC_SRC_NO_MAC])
            code_of = `SEBC_CODE_NO_MAC;
         else if (f[`SEBC_SRC_STDIO])
            code_of = `SEBC_CODE_STDIO;
         else if (f[`SEBC_SRC_THREAD1])
            code_of = `SEBC_CODE_THREAD1;
         else if (f[`SEBC_SRC_THREAD2])
            code_of = `SEBC_CODE_THREAD2;
         else if (f[`SEBC_SRC_POST_DMA])
            code_of = `SEBC_CODE_POST_DMA;
         else if (f[`SEBC_SRC_POST_MEMDMA])
            code_of = `SEBC_CODE_POST_MDMA;
         else if (f[`SEBC_SRC_POST_ETH])
            code_of = `SEBC_CODE_POST_ETH;
         else if (f[`SEBC_SRC_POST_IRQ])
            code_of = `SEBC_CODE_POST_IRQ;
         else if (f[`SEBC_SRC_POST_MII])
            code_of = `SEBC_CODE_POST_MII;
         else if (f[`SEBC_SRC_POST_CACHE])
            code_of = `SEBC_CODE_POST_CACHE;
         else
            code_of = `SEBC_CODE_NONE;
      end
   endfunction

   // -------------------------------------------------------------------------
   // Input synchroniser
   // -------------------------------------------------------------------------
   reg [18:0] fault_meta;
   reg [18:0] fault_sync;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fault_meta <= 19'h00000;
         fault_sync <= 19'h00000;
      end else begin
         fault_meta <= fault_in;
         fault_sync <= fault_meta;
      end
   end

   // -------------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------------
   reg [2:0]  state;
   reg [26:0] period_cnt;
   reg [26:0] phase_cnt;
   reg [4:0]  blinks_left;
   wire [4:0] new_code = code_of(fault_sync);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state           <= ST_IDLE;
         period_cnt      <= 27'h0000000;
         phase_cnt       <= 27'h0000000;
         blinks_left     <= 5'h00;
         error_code      <= `SEBC_CODE_NONE;
         error_active    <= 1'b0;
         green_indicator <= 1'b0;
         red_indicator   <= 1'b0;
      end else begin
         if (!error_active) begin
            // First fault latches; later faults are ignored until reset
            if (new_code != `SEBC_CODE_NONE) begin
               error_code      <= new_code;
               error_active    <= 1'b1;
               blinks_left     <= new_code - 5'h01;
               state           <= ST_ON;
               period_cnt      <= 27'h0000000;
               phase_cnt       <= 27'h0000000;
               green_indicator <= 1'b1;
               red_indicator   <= 1'b1;
            end
         end else begin
            // Period restart: begin a new group of blinks
            if (period_cnt == PERIOD_CYC - 27'h0000001) begin
               period_cnt      <= 27'h0000000;
               phase_cnt       <= 27'h0000000;
               blinks_left     <= error_code - 5'h01;
               state           <= ST_ON;
               green_indicator <= 1'b1;
               red_indicator   <= 1'b1;
            end else begin
               period_cnt <= period_cnt + 27'h0000001;
               case (state)
                  ST_ON: begin
                     if (phase_cnt == ON_CYC - 27'h0000001) begin
                        phase_cnt       <= 27'h0000000;
                        state           <= ST_OFF;
                        green_indicator <= 1'b0;
                        red_indicator   <= 1'b0;
                     end else begin
                        phase_cnt <= phase_cnt + 27'h0000001;
                     end
                  end
                  ST_OFF: begin
                     if (phase_cnt == OFF_CYC - 27'h0000001 &&
                         blinks_left != 5'h00) begin
                        phase_cnt       <= 27'h0000000;
                        blinks_left     <= blinks_left - 5'h01;
                        state           <= ST_ON;
                        green_indicator <= 1'b1;
                        red_indicator   <= 1'b1;
                     end else if (phase_cnt != OFF_CYC - 27'h0000001) begin
                        phase_cnt <= phase_cnt + 27'h0000001;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_IDLE: begin
                     green_indicator <= 1'b0;
                     red_indicator   <= 1'b0;
                  end
                  default: begin
                     state           <= ST_IDLE;
                     green_indicator <= 1'b0;
                     red_indicator   <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

endmodule // sebc_blink

// ### sebc_lamp_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Operator view of the two front-panel lamps
// ----------------------------------------------------------------------------
module sebc_lamp_model (
   input  wire green_indicator, // Green lamp, high = lit
   input  wire red_indicator,   // Red lamp, high = lit
   output wire lit,             // Both lamps seen lit
   output wire split            // Lamps seen in different states
);
   assign lit   = green_indicator & red_indicator;
   assign split = green_indicator ^ red_indicator;
endmodule // sebc_lamp_model

// ### sebc_blink_chk.sv
`timescale 1ns/1ps
module sebc_blink_chk (
   input wire        clk_sys,         // System clock
   input wire        reset_n,         // Reset, active low
   input wire [18:0] fault_in,        // Fault sources
   input wire        green_indicator, // Green lamp
   input wire        red_indicator,   // Red lamp
   input wire [4:0]  error_code,      // Latched code
   input wire        error_active     // Code latched
);
   localparam int ON  = 7500000;
   localparam int PER = 50000000;
   int pcnt;
   // Cycles since latch, restarting each period
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         pcnt <= 0;
      else if (error_active)
         pcnt <= (pcnt == PER - 1) ? 0 : pcnt + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_lamps_paired: assert property (
      green_indicator == red_indicator) else $error("lamps differ");
   chk_idle_dark: assert property (
      !error_active |-> !green_indicator && error_code == 5'h00)
      else $error("lamp or code without error");
   chk_latch_delay: assert property (
      !error_active && fault_in != 0 && $past(fault_in) == 0
      |-> ##2 !error_active ##1 error_active) else $error("latch delay");
   chk_latch_lights: assert property (
      $rose(error_active) |-> green_indicator && error_code != 5'h00)
      else $error("latch without lamp");
   chk_first_blink: assert property (
      error_active && pcnt < ON |-> green_indicator)
      else $error("first blink short");
   chk_first_gap: assert property (
      error_active && pcnt >= ON && pcnt < 2 * ON |-> !green_indicator)
      else $error("first gap lit");
   chk_single_dark: assert property (
      error_active && error_code == 5'h01 && pcnt >= ON |-> !green_indicator)
      else $error("code one extra blink");
   chk_code_held: assert property (
      error_active |=> error_active && $stable(error_code))
      else $error("code changed");
   chk_no_fourteen: assert property (
      error_code != 5'h0E) else $error("code fourteen");
endmodule // sebc_blink_chk

// ### sebc_blink_tb.sv
`timescale 1ns/1ps
module sebc_blink_tb;
   logic        clk_sys;
   logic        reset_n;
   logic [18:0] fault_in;
   wire         green_indicator;
   wire         red_indicator;
   wire  [4:0]  error_code;
   wire         error_active;
   wire         lit;
   wire         split;
   int          errors;
   int          checks;
   sebc_blink dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .fault_in(fault_in), .green_indicator(green_indicator),
      .red_indicator(red_indicator), .error_code(error_code),
      .error_active(error_active));
   sebc_lamp_model lamps (.green_indicator(green_indicator),
      .red_indicator(red_indicator), .lit(lit), .split(split));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic cmp_code(input logic [4:0] got, input logic [4:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic do_reset();
      @(negedge clk_sys);
      fault_in = 19'h00000;
      reset_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      reset_n = 1'b1;
      @(negedge clk_sys);
      cmp_code(error_code, 5'h00);
      cmp_bit(lit | split, 1'b0);
   endtask
   task automatic raise(input logic [18:0] bits);
      @(negedge clk_sys);
      fault_in = bits;
      repeat (2) @(negedge clk_sys);
      cmp_bit(error_active, 1'b0);
      @(negedge clk_sys);
      cmp_bit(error_active, 1'b1);
      cmp_bit(lit, 1'b1);
      cmp_bit(split, 1'b0);
   endtask
   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_codes();
      logic [4:0] e;
      for (int b = 0; b < 19; b++) begin
         do_reset();
         raise(19'h00001 << b);
         e = 5'((b < 13) ? b + 1 : b + 2);
         if (b < 9) cmp_code(error_code, e);
         else if (b < 13) cmp_code(error_code, e);
         else cmp_code(error_code, e);
      end
      $display("test codes done");
   endtask
   task automatic test_hold();
      do_reset();
      raise(19'h03000);
      cmp_code(error_code, 5'h0D);
      @(negedge clk_sys);
      fault_in = 19'h00001;
      repeat (6) @(negedge clk_sys);
      cmp_code(error_code, 5'h0D);
      fault_in = 19'h00000;
      repeat (6) @(negedge clk_sys);
      cmp_code(error_code, 5'h0D);
      cmp_bit(error_active & lit, 1'b1);
      $display("test hold done");
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      fault_in = 19'h00000;
      errors = 0;
      checks = 0;
      test_codes();
      test_hold();
      close_out();
   end
   initial begin
      #400000;
      errors++;
      close_out();
   end
endmodule // sebc_blink_tb
bind sebc_blink sebc_blink_chk chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .fault_in(fault_in), .green_indicator(green_indicator),
   .red_indicator(red_indicator), .error_code(error_code),
   .error_active(error_active));
